// file: bench/nfd_host_model.sv
// apb master standing in for host software
`timescale 1ns/10ps
module nfd_host_model (
  input wire logic i_clk,
  input wire logic i_pready,
  input wire logic i_pslverr,
  input wire logic [31:0] i_prdata,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [11:0] o_paddr,
  output logic [31:0] o_pwdata,
  output logic [3:0] o_pstrb
);
  // idle bus at time zero
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 12'h000;
    o_pwdata = 32'h0;
    o_pstrb = 4'hf;
  end
  // one transfer; x results flag a hung slave
  task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [3:0] s,
      output logic [31:0] q, output logic e);
    int n = 0;
    q = 32'hx;
    e = 1'bx;
    @(posedge i_clk);
    o_psel <= 1'b1;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    o_pstrb <= s;
    @(posedge i_clk);
    o_penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_pready !== 1'b1 && n < 50);
    if (i_pready === 1'b1) begin
      q = i_prdata;
      e = i_pslverr;
    end
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    o_paddr <= ~a; // released lines must not look valid
    o_pwdata <= ~d;
  endtask
endmodule

// file: bench/nfd_monitor.sv
// assertion checker for the descriptor register bank ports
`timescale 1ns/10ps
module nfd_monitor #(
  parameter int NUM_FORMATS = 16
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RSTN,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic [7:0] O_FORMAT_COUNT,
  input wire logic [7:0] O_ACTIVE_FORMAT,
  input wire logic [7:0] O_META_CAPS,
  input wire logic [7:0] O_PROT_CAPS
);
  // ====================
  // bus answer timing
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RSTN);
  ready_wait_a: assert property (
    I_PSEL && !I_PENABLE |=> !O_PREADY ##1 O_PREADY)
    else $error("ready not two cycles after setup");
  ready_pulse_a: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (O_PSLVERR |-> O_PREADY)
    else $error("error without ready");
  // ====================
  // reported bytes and idle read data
  act_reserved_a: assert property (O_ACTIVE_FORMAT[7:5] == 3'h0)
    else $error("active format reserved bits set");
  meta_reserved_a: assert property (O_META_CAPS[7:2] == 6'h00)
    else $error("metadata caps reserved bits set");
  prot_reserved_a: assert property (O_PROT_CAPS[7:5] == 3'h0)
    else $error("protection caps reserved bits set");
  count_max_a: assert property (O_FORMAT_COUNT < NUM_FORMATS)
    else $error("format count too large");
  ext_mode_a: assert property (
    (O_META_CAPS[1:0] == 2'h1 |-> O_ACTIVE_FORMAT[4]) and
    (O_META_CAPS[1:0] == 2'h2 |-> !O_ACTIVE_FORMAT[4]))
    else $error("transfer mode not supported");
  index_range_a: assert property (
    {4'h0, O_ACTIVE_FORMAT[3:0]} <= O_FORMAT_COUNT)
    else $error("active index beyond format count");
  idle_data_a: assert property (!O_PREADY |-> O_PRDATA == 32'h0000_0000)
    else $error("read data outside ready cycle");
endmodule

// file: bench/nfd_regbank_tb_top.sv
// self-checking bench for the descriptor register bank
`timescale 1ns/10ps
module nfd_regbank_tb_top;
  localparam logic [32:0] ERR = 33'h1_0000_0000;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel, pen, pwr, rdy, err;
  logic [11:0] addr;
  logic [31:0] wd, rq;
  logic [3:0] strb;
  logic [3:0] lane = 4'hf;
  logic [7:0] fc, af, mc, pc;
  int n_errors = 0;
  int check_count = 0;
  nfd_regbank #(.NUM_FORMATS(16)) dut_u (
    .I_CORE_CLK(clk), .I_RSTN(rstn), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(addr), .I_PWDATA(wd), .I_PSTRB(strb),
    .O_PRDATA(rq), .O_PREADY(rdy), .O_PSLVERR(err),
    .O_FORMAT_COUNT(fc), .O_ACTIVE_FORMAT(af), .O_META_CAPS(mc),
    .O_PROT_CAPS(pc));
  nfd_host_model host_u (
    .i_clk(clk), .i_pready(rdy), .i_pslverr(err), .i_prdata(rq),
    .o_psel(psel), .o_penable(pen), .o_pwrite(pwr), .o_paddr(addr),
    .o_pwdata(wd), .o_pstrb(strb));
  // 100 MHz core clock
  always #5 clk = ~clk;
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // error flag above data; write data is never judged
  task automatic acc(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [32:0] x);
    logic [31:0] q;
    logic e;
    host_u.xfer(w, a, d, lane, q, e);
    chk({e, w ? 32'h0 : q}, x);
  endtask
  task automatic rd(input logic [9:0] i, input logic [32:0] x);
    acc(1'b0, {i, 2'b00}, 32'h0, x);
  endtask
  task automatic wr(input logic [9:0] i, input logic [31:0] d);
    acc(1'b1, {i, 2'b00}, d, 33'h0);
  endtask
  task automatic t_reset();
    chk({1'b0, fc, af, mc, pc}, 33'h0);
    rd(nfd_pkg::IDX_DESC0, {1'b0, nfd_pkg::RST_DESC});
  endtask
  task automatic t_count();
    logic [15:0] s [4] = '{16'h0007, 16'h000b, 16'hffff, 16'h0000};
    logic [7:0] n [4] = '{8'h02, 8'h01, 8'h0f, 8'h00};
    for (int k = 0; k < 4; k++) begin
      wr(nfd_pkg::IDX_CFG_SLOTS, {16'h0, s[k]});
      rd(nfd_pkg::IDX_FMT_COUNT, {25'h0, n[k]});
      chk({25'h0, fc}, {25'h0, n[k]});
    end
  endtask
  task automatic t_desc();
    wr(nfd_pkg::IDX_CFG_SLOTS, 32'hf);
    wr(nfd_pkg::IDX_DESC0 + 10'h00c, 32'h0002_0c08);
    rd(nfd_pkg::IDX_DESC0 + 10'h00c, 33'h0002_0c08);
    wr(nfd_pkg::IDX_CFG_SLOTS, 32'h7);
    rd(nfd_pkg::IDX_DESC0 + 10'h00c, 33'h0);
    rd(nfd_pkg::IDX_DESC0 + 10'h001, ERR);
    rd(nfd_pkg::IDX_DESC_LAST + 10'h004, ERR);
  endtask
  task automatic t_active();
    wr(nfd_pkg::IDX_CFG_SLOTS, 32'hf);
    wr(nfd_pkg::IDX_CFG_GEOM, 32'h100c);
    wr(nfd_pkg::IDX_CFG_MCAPS, 32'h1);
    wr(nfd_pkg::IDX_CFG_ACTIVE, 32'h3);
    rd(nfd_pkg::IDX_ACTIVE, 33'h13);
    chk({25'h0, af}, 33'h13);
    wr(nfd_pkg::IDX_CFG_ACTIVE, 32'h5);
    rd(nfd_pkg::IDX_ACTIVE, 33'h10);
    wr(nfd_pkg::IDX_CFG_MCAPS, 32'h2);
    wr(nfd_pkg::IDX_CFG_ACTIVE, 32'h12);
    rd(nfd_pkg::IDX_ACTIVE, 33'h02);
    wr(nfd_pkg::IDX_CFG_MCAPS, 32'hff);
    rd(nfd_pkg::IDX_META_CAPS, 33'h03);
    chk({25'h0, mc}, 33'h03);
    rd(nfd_pkg::IDX_ACTIVE, 33'h12);
    wr(nfd_pkg::IDX_CFG_GEOM, 32'h000c);
    rd(nfd_pkg::IDX_META_CAPS, 33'h00);
  endtask
  task automatic t_prot();
    wr(nfd_pkg::IDX_CFG_GEOM, 32'h0809);
    for (int b = 0; b < 8; b++) begin
      wr(nfd_pkg::IDX_CFG_PCAPS, 32'h1 << b);
      rd(nfd_pkg::IDX_PROT_CAPS, {32'h0, b < 5} << b);
    end
    wr(nfd_pkg::IDX_CFG_PCAPS, 32'hff);
    repeat (2) @(posedge clk);
    chk({25'h0, pc}, 33'h1f);
    wr(nfd_pkg::IDX_CFG_GEOM, 32'h0709);
    rd(nfd_pkg::IDX_PROT_CAPS, 33'h0);
    rd(nfd_pkg::IDX_STATUS, 33'h1c);
    wr(nfd_pkg::IDX_CFG_GEOM, 32'h100c);
    rd(nfd_pkg::IDX_STATUS, 33'h0);
    // one strobed lane only: metadata byte count drops to seven
    lane = 4'h2;
    wr(nfd_pkg::IDX_CFG_GEOM, 32'hffff_07ff);
    lane = 4'hf;
    rd(nfd_pkg::IDX_CFG_GEOM, 33'h070c);
    rd(nfd_pkg::IDX_PROT_CAPS, {25'h0, pc});
    chk({25'h0, pc}, 33'h0);
  endtask
  // refused accesses leave the reported bytes alone
  task automatic t_refuse();
    acc(1'b1, 12'h064, 32'h5, ERR);
    rd(nfd_pkg::IDX_FMT_COUNT, 33'h3);
    acc(1'b0, 12'h065, 32'h0, ERR);
    acc(1'b0, 12'h7fc, 32'h0, ERR);
    acc(1'b1, 12'h414, 32'h1, ERR);
  endtask
  // asynchronous reset in mid-run puts the configuration back
  task automatic t_rerst();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    chk({1'b0, fc, af, mc, pc}, 33'h0);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    chk({25'h0, fc}, 33'h0);
    rd(nfd_pkg::IDX_CFG_SLOTS, {17'h0, nfd_pkg::RST_SLOTS});
    rd(nfd_pkg::IDX_CFG_GEOM, {1'b0, nfd_pkg::RST_GEOM});
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // watchdog far beyond the few hundred cycles needed
  initial begin
    #100000;
    n_errors++;
    stop_test();
  end
  // reset, then the scenarios in turn
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_count();
    t_desc();
    t_active();
    t_prot();
    t_refuse();
    t_rerst();
    stop_test();
  end
endmodule
bind nfd_regbank nfd_monitor #(.NUM_FORMATS(NUM_FORMATS)) mon_u (
  .I_CORE_CLK, .I_RSTN, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR,
  .I_PWDATA, .I_PSTRB, .O_PRDATA, .O_PREADY, .O_PSLVERR,
  .O_FORMAT_COUNT, .O_ACTIVE_FORMAT, .O_META_CAPS, .O_PROT_CAPS);

// file: verilog/nfd_pkg.sv
// constants shared by the namespace format descriptor register bank
// ===================================================================
// ===================================================================
package nfd_pkg;
  // ===================================================================
  // register indices; the byte address is four times the index
  localparam logic [9:0] IDX_FMT_COUNT = 10'h019;
  localparam logic [9:0] IDX_ACTIVE = 10'h01a;
  localparam logic [9:0] IDX_META_CAPS = 10'h01b;
  localparam logic [9:0] IDX_PROT_CAPS = 10'h01c;
  localparam logic [9:0] IDX_DESC0 = 10'h080;
  localparam logic [9:0] IDX_DESC_LAST = 10'h0bc;
  localparam logic [9:0] IDX_CFG_SLOTS = 10'h100;
  localparam logic [9:0] IDX_CFG_ACTIVE = 10'h101;
  localparam logic [9:0] IDX_CFG_MCAPS = 10'h102;
  localparam logic [9:0] IDX_CFG_PCAPS = 10'h103;
  localparam logic [9:0] IDX_CFG_GEOM = 10'h104;
  localparam logic [9:0] IDX_STATUS = 10'h105;
  // ===================================================================
  // field positions
  localparam int ACT_IDX_W = 4;
  localparam int ACT_EXT_BIT = 4;
  localparam int MC_EXT_BIT = 0;
  localparam int MC_SEP_BIT = 1;
  localparam int MC_W = 2;
  localparam int PC_W = 5;
  localparam int GEOM_META_LSB = 8;
  localparam int ST_W = 5;
  // ===================================================================
  // values after reset and thresholds
  localparam logic [15:0] RST_SLOTS = 16'h0001;
  localparam logic [7:0] RST_ACTIVE = 8'h00;
  localparam logic [7:0] RST_MCAPS = 8'h00;
  localparam logic [7:0] RST_PCAPS = 8'h00;
  localparam logic [31:0] RST_GEOM = 32'h0000_0009;
  localparam logic [31:0] RST_DESC = 32'h0000_0000;
  localparam logic [7:0] MIN_BLOCK_LOG2 = 8'h0c;
  localparam logic [15:0] MIN_META_PI = 16'h0008;
endpackage

// file: verilog/nfd_regbank.sv
// apb register bank reporting one namespace's format descriptor fields
`timescale 1ns/10ps
module nfd_regbank #(
  parameter int NUM_FORMATS = 16
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RSTN,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic [7:0] O_FORMAT_COUNT,
  output logic [7:0] O_ACTIVE_FORMAT,
  output logic [7:0] O_META_CAPS,
  output logic [7:0] O_PROT_CAPS
);

  // ===================================================================
  // declarations
  // local copy of the status width, needed before the status registers
  localparam int ST_W = nfd_pkg::ST_W;
  logic [15:0] slots;
  logic [15:0] next_slots;
  logic [7:0] cfg_active;
  logic [7:0] next_cfg_active;
  logic [7:0] cfg_mcaps;
  logic [7:0] next_cfg_mcaps;
  logic [7:0] cfg_pcaps;
  logic [7:0] next_cfg_pcaps;
  logic [31:0] cfg_geom;
  logic [31:0] next_cfg_geom;
  logic [31:0] desc [NUM_FORMATS];
  logic [NUM_FORMATS-1:0] pop;
  logic [NUM_FORMATS-1:0] next_pop;
  logic [7:0] rep_count;
  logic [7:0] next_rep_count;
  logic [7:0] rep_active;
  logic [7:0] next_rep_active;
  logic [7:0] rep_mcaps;
  logic [7:0] next_rep_mcaps;
  logic [7:0] rep_pcaps;
  logic [7:0] next_rep_pcaps;
  logic [ST_W-1:0] status;
  logic [ST_W-1:0] next_status;
  logic pready;
  logic next_pready;
  logic pslverr;
  logic next_pslverr;
  logic [31:0] prdata;
  logic [31:0] next_prdata;
  logic [9:0] idx;
  logic hit;
  logic read_only;
  logic desc_hit;
  logic [3:0] desc_slot;
  logic [31:0] rd_word;
  logic commit;
  logic wr_ok;
  logic [31:0] wr_word;

  // ===================================================================
  // byte-lane merge for writes
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] wdata,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = wdata[8*b +: 8];
      end
    end
    return res;
  endfunction

  // ===================================================================
  // address decode; a misaligned address is treated as unmapped
  assign idx = I_PADDR[11:2];
  assign desc_slot = idx[5:2];

  always_comb begin
    desc_hit = (idx >= nfd_pkg::IDX_DESC0) &&
      (idx <= nfd_pkg::IDX_DESC_LAST) && (idx[1:0] == 2'b00) &&
      (int'(desc_slot) < NUM_FORMATS);
    hit = 1'b1;
    read_only = 1'b0;
    rd_word = 32'h0000_0000;
    if (desc_hit) begin
      // unpopulated slots read zero, so gaps never show
      rd_word = pop[desc_slot] ? desc[desc_slot] : 32'h0000_0000;
    end else begin
      unique case (idx)
        nfd_pkg::IDX_FMT_COUNT: begin
          rd_word = {24'h00_0000, rep_count};
          read_only = 1'b1;
        end
        nfd_pkg::IDX_ACTIVE: begin
          rd_word = {24'h00_0000, rep_active};
          read_only = 1'b1;
        end
        nfd_pkg::IDX_META_CAPS: begin
          rd_word = {24'h00_0000, rep_mcaps};
          read_only = 1'b1;
        end
        nfd_pkg::IDX_PROT_CAPS: begin
          rd_word = {24'h00_0000, rep_pcaps};
          read_only = 1'b1;
        end
        nfd_pkg::IDX_CFG_SLOTS: begin
          rd_word = {16'h0000, slots};
        end
        nfd_pkg::IDX_CFG_ACTIVE: begin
          rd_word = {24'h00_0000, cfg_active};
        end
        nfd_pkg::IDX_CFG_MCAPS: begin
          rd_word = {24'h00_0000, cfg_mcaps};
        end
        nfd_pkg::IDX_CFG_PCAPS: begin
          rd_word = {24'h00_0000, cfg_pcaps};
        end
        nfd_pkg::IDX_CFG_GEOM: begin
          rd_word = cfg_geom;
        end
        nfd_pkg::IDX_STATUS: begin
          rd_word = {{(32-ST_W){1'b0}}, status};
          read_only = 1'b1;
        end
        default: begin
          hit = 1'b0;
        end
      endcase
    end
    if (I_PADDR[1:0] != 2'b00) begin
      hit = 1'b0;
    end
  end

  // ===================================================================
  // apb handshake: one wait state, answer in the second access cycle
  assign commit = I_PSEL && I_PENABLE && pready;
  assign wr_ok = commit && I_PWRITE && hit && !read_only;
  // merging over the read word keeps lanes identical to what reads show
  assign wr_word = merge(rd_word, I_PWDATA, I_PSTRB);

  always_comb begin
    next_pready = I_PSEL && I_PENABLE && !pready;
    next_pslverr = 1'b0;
    next_prdata = 32'h0000_0000;
    if (I_PSEL && I_PENABLE && !pready) begin
      // writes to reported bytes are refused, they mirror hardware
      next_pslverr = !hit || (I_PWRITE && read_only);
      if (!I_PWRITE && hit) begin
        next_prdata = rd_word;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  // ===================================================================
  // configuration written by controller firmware
  always_comb begin
    next_slots = slots;
    next_cfg_active = cfg_active;
    next_cfg_mcaps = cfg_mcaps;
    next_cfg_pcaps = cfg_pcaps;
    next_cfg_geom = cfg_geom;
    if (wr_ok && !desc_hit) begin
      unique case (idx)
        // strobed lanes come from the merged word, the rest keep value
        nfd_pkg::IDX_CFG_SLOTS: begin
          next_slots = wr_word[15:0];
        end
        nfd_pkg::IDX_CFG_ACTIVE: begin
          next_cfg_active = wr_word[7:0];
        end
        nfd_pkg::IDX_CFG_MCAPS: begin
          next_cfg_mcaps = wr_word[7:0];
        end
        nfd_pkg::IDX_CFG_PCAPS: begin
          next_cfg_pcaps = wr_word[7:0];
        end
        nfd_pkg::IDX_CFG_GEOM: begin
          next_cfg_geom = wr_word;
        end
        // reported bytes and status are refused before this point
        default: begin
          next_slots = slots;
        end
      endcase
    end
    next_slots[0] = 1'b1; // slot zero always present
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      slots <= nfd_pkg::RST_SLOTS;
      cfg_active <= nfd_pkg::RST_ACTIVE;
      cfg_mcaps <= nfd_pkg::RST_MCAPS;
      cfg_pcaps <= nfd_pkg::RST_PCAPS;
      cfg_geom <= nfd_pkg::RST_GEOM;
    end else begin
      slots <= next_slots;
      cfg_active <= next_cfg_active;
      cfg_mcaps <= next_cfg_mcaps;
      cfg_pcaps <= next_cfg_pcaps;
      cfg_geom <= next_cfg_geom;
    end
  end

  // ===================================================================
  // descriptor slots, one word each, written through their own address
  for (genvar g = 0; g < NUM_FORMATS; g++) begin : g_desc
    logic [31:0] next_desc;

    always_comb begin
      next_desc = desc[g];
      if (wr_ok && desc_hit && (int'(desc_slot) == g)) begin
        next_desc = merge(desc[g], I_PWDATA, I_PSTRB);
      end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
        desc[g] <= nfd_pkg::RST_DESC;
      end else begin
        desc[g] <= next_desc;
      end
    end
  end

  // ===================================================================
  // reported bytes, rebuilt from configuration every cycle
  always_comb begin
    logic run;
    logic [7:0] n;
    logic [15:0] meta;
    logic [nfd_pkg::MC_W-1:0] mc;
    logic want_ext;
    logic ext;
    logic [nfd_pkg::ACT_IDX_W-1:0] sel;
    run = 1'b1;
    n = 8'h00;
    meta = cfg_geom[nfd_pkg::GEOM_META_LSB +: 16];
    mc = 2'b00;
    want_ext = cfg_active[nfd_pkg::ACT_EXT_BIT];
    ext = want_ext;
    sel = cfg_active[nfd_pkg::ACT_IDX_W-1:0];
    next_status = '0;
    // only the unbroken run from slot zero counts; a gap ends it
    for (int k = 0; k < NUM_FORMATS; k++) begin
      run = run & slots[k];
      next_pop[k] = run;
      n = n + {7'h00, run};
    end
    next_rep_count = n - 8'h01; // zero-based count
    // a namespace without metadata offers no transfer mode
    if (meta != 16'h0000) begin
      mc = cfg_mcaps[nfd_pkg::MC_W-1:0];
    end
    next_rep_mcaps = {6'h00, mc}; // reserved 7:2 stay zero
    // the chosen index must name a populated slot
    if ({4'h0, sel} >= n) begin
      sel = '0;
      next_status[0] = 1'b1;
    end
    // a single bit picks the mode, so metadata never splits
    if (want_ext && !mc[nfd_pkg::MC_EXT_BIT] &&
        mc[nfd_pkg::MC_SEP_BIT]) begin
      ext = 1'b0;
      next_status[1] = 1'b1;
    end else if (!want_ext && !mc[nfd_pkg::MC_SEP_BIT] &&
        mc[nfd_pkg::MC_EXT_BIT]) begin
      ext = 1'b1;
      next_status[1] = 1'b1;
    end
    next_rep_active = {3'h0, ext, sel}; // bits 7:5 zero
    // hints only; nothing is blocked on them
    next_status[2] = cfg_geom[7:0] < nfd_pkg::MIN_BLOCK_LOG2;
    next_status[3] = (meta != 16'h0000) && (meta < nfd_pkg::MIN_META_PI);
    // protection needs eight metadata bytes to live
    if (meta >= nfd_pkg::MIN_META_PI) begin
      // several capability bits may be set together
      // bit 4 last, bit 3 first, bits 2:0 types
      next_rep_pcaps = {3'h0, cfg_pcaps[nfd_pkg::PC_W-1:0]};
    end else begin
      next_rep_pcaps = 8'h00;
      next_status[4] = cfg_pcaps[nfd_pkg::PC_W-1:0] != 5'h00;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      pop <= '0;
      rep_count <= 8'h00;
      rep_active <= 8'h00;
      rep_mcaps <= 8'h00;
      rep_pcaps <= 8'h00;
      status <= '0;
    end else begin
      pop <= next_pop;
      rep_count <= next_rep_count;
      rep_active <= next_rep_active;
      rep_mcaps <= next_rep_mcaps;
      rep_pcaps <= next_rep_pcaps;
      status <= next_status;
    end
  end

  // ===================================================================
  // outputs, all straight from flip-flops
  assign O_PRDATA = prdata;
  assign O_PREADY = pready;
  assign O_PSLVERR = pslverr;
  assign O_FORMAT_COUNT = rep_count;
  assign O_ACTIVE_FORMAT = rep_active;
  assign O_META_CAPS = rep_mcaps;
  assign O_PROT_CAPS = rep_pcaps;

endmodule
